// [rtl/nrim_regs.vh]
/*
 * register offsets, field positions, reset values and timing counts
 * of the interrupt status and mask block.
 * assumes: included by bare name from rtl files, definitions only.
 */
`ifndef NRIM_REGS_VH
`define NRIM_REGS_VH

// register port
`define NRIM_ADDR_W       6
`define NRIM_DATA_W       8
`define NRIM_MAIN_MASK    6'h14
`define NRIM_TNFC_MASK    6'h15
`define NRIM_ERR_MASK     6'h16
`define NRIM_MAIN_STAT    6'h17
`define NRIM_TNFC_STAT    6'h18
`define NRIM_ERR_STAT     6'h19
`define NRIM_RESET_VAL    8'h00
`define NRIM_MAIN_RDCLR   8'hfc

// main status fields
`define NRIM_M_OSC        7
`define NRIM_M_WL         6
`define NRIM_M_RXS        5
`define NRIM_M_RXE        4
`define NRIM_M_TXE        3
`define NRIM_M_COL        2
`define NRIM_M_TIM        1
`define NRIM_M_ERR        0

// timer and nfc status fields
`define NRIM_T_DCT        7
`define NRIM_T_NRE        6
`define NRIM_T_GPE        5
`define NRIM_T_EON        4
`define NRIM_T_EOF        3
`define NRIM_T_CAC        2
`define NRIM_T_CAT        1
`define NRIM_T_NFCT       0

// error and wake-up fields
`define NRIM_E_SOFT       5
`define NRIM_E_HARD       4
`define NRIM_E_WT         3

// timing
`define NRIM_CLK_MHZ      40
`define NRIM_GUARD_US     1000
`define NRIM_GUARD_W      24

`endif

// [rtl/nrim_flag_bank.v]
/*
 * bank of sticky status flags, one per bit.
 * assumes: set, clear and clear-all come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module nrim_flag_bank #(
   parameter W = 8
) (
   input  wire         clock,
   input  wire         rst,
   input  wire         clr_all,
   input  wire [W-1:0] set_vec,
   input  wire [W-1:0] clr_vec,
   output wire [W-1:0] flags
);

   reg [W-1:0] flag_reg;

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         // set beats clear so an event in the read cycle survives
         always @(posedge clock) begin
            if (rst || clr_all) begin
               flag_reg[i] <= 1'b0;
            end else if (set_vec[i]) begin
               flag_reg[i] <= 1'b1;
            end else if (clr_vec[i]) begin
               flag_reg[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign flags = flag_reg;

endmodule // nrim_flag_bank

`default_nettype wire

// [rtl/nrim_guard_timer.v]
/*
 * one-shot down counter for the guard time after own field switch-on.
 * assumes: start and abort are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "nrim_regs.vh"

module nrim_guard_timer #(
   parameter CYCLES = 40000
) (
   input  wire clock,
   input  wire rst,
   input  wire abort,
   input  wire start,
   output wire busy,
   output wire done
);

   // cut to the counter width on purpose, counts above it wrap
   localparam integer             LOAD_I = CYCLES - 1;
   localparam [`NRIM_GUARD_W-1:0] LOAD   = LOAD_I[`NRIM_GUARD_W-1:0];

   reg [`NRIM_GUARD_W-1:0] count_reg;
   reg                     busy_reg;
   reg                     done_reg;

   always @(posedge clock) begin
      if (rst || abort) begin
         count_reg <= {`NRIM_GUARD_W{1'b0}};
         busy_reg  <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (start) begin
            count_reg <= LOAD;
            busy_reg  <= 1'b1;
         end else if (busy_reg) begin
            if (count_reg == {`NRIM_GUARD_W{1'b0}}) begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end else begin
               count_reg <= count_reg - 1'b1;
            end
         end
      end
   end

   assign busy = busy_reg;
   assign done = done_reg;

endmodule // nrim_guard_timer

`default_nettype wire

// [rtl/nrim_top.v]
/*
 * interrupt status and mask logic of an hf reader / nfc device:
 * three mask registers, three read-to-clear status registers (main summary bits clear on the tnfc and err reads),
 * rf collision avoidance sequencing and the interrupt request output.
 * assumes: event inputs are one-cycle pulses or levels on clock,
 * except osc_stable_pin and ext_field_pin, which are asynchronous.
 */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "nrim_regs.vh"

module nrim_top #(
   parameter GUARD_CYCLES = `NRIM_GUARD_US * `NRIM_CLK_MHZ
) (
   input  wire                    clock,
   input  wire                    rst,
   // register port
   input  wire [`NRIM_ADDR_W-1:0] addr,
   input  wire [`NRIM_DATA_W-1:0] wdata,
   input  wire                    wr_en,
   input  wire                    rd_en,
   output wire [`NRIM_DATA_W-1:0] rdata,
   // commands and operating state
   input  wire                    set_default_cmd,
   input  wire                    osc_enable,
   input  wire                    osc_stable_pin,
   input  wire                    rx_active,
   input  wire                    tx_active,
   input  wire                    fifo_near_full,
   input  wire                    fifo_near_empty,
   // receive / transmit events
   input  wire                    rx_start,
   input  wire                    rx_end,
   input  wire                    tx_end,
   input  wire                    bit_collision,
   // timer and nfc events
   input  wire                    dir_cmd_done,
   input  wire                    nrt_expire,
   input  wire                    gpt_expire,
   input  wire                    ext_field_pin,
   input  wire                    ca_start,
   input  wire                    target_mode,
   input  wire                    bitrate_found,
   // error and wake-up events, bit order of the status register
   input  wire [7:0]              err_events,
   // results
   output wire                    irq,
   output wire                    field_on
);

   ////////////////////////////////////////////////////////////
   // declarations

   localparam [2:0] CA_IDLE  = 3'b001;
   localparam [2:0] CA_SENSE = 3'b010;
   localparam [2:0] CA_GUARD = 3'b100;

   reg  [7:0] main_mask_reg;
   reg  [7:0] tnfc_mask_reg;
   reg  [7:0] err_mask_reg;
   reg  [7:0] rdata_reg;
   reg  [7:0] rdata_next;
   reg        irq_reg;
   reg        field_on_reg;
   reg  [2:0] ca_state_reg;
   reg  [2:0] ca_state_next;

   reg        osc_meta_reg;
   reg        osc_sync_reg;
   reg        osc_prev_reg;
   reg        fld_meta_reg;
   reg        fld_sync_reg;
   reg        fld_prev_reg;
   reg        wl_prev_reg;

   wire [7:0] main_flags;
   wire [7:0] tnfc_flags;
   wire [7:0] err_flags;
   reg  [7:0] main_set;
   reg  [7:0] main_clr;
   reg  [7:0] tnfc_set;
   wire [7:0] tnfc_clr;
   wire [7:0] err_set;
   wire [7:0] err_clr;

   wire       rd_main;
   wire       rd_tnfc;
   wire       rd_err;
   wire       fifo_level_flag;
   wire       osc_rise;
   wire       fld_rise;
   wire       fld_fall;
   wire       wl_level;
   wire       ca_collide;
   wire       ca_clear;
   wire       guard_done;
   wire       mask_soft_framing;
   wire       mask_hard_framing;
   wire       mask_wakeup_timer;
   wire [7:0] main_pend;
   wire [7:0] tnfc_pend;
   wire [7:0] err_pend;

   ////////////////////////////////////////////////////////////
   // functions

   function hit;
      input [`NRIM_ADDR_W-1:0] a;
      input [`NRIM_ADDR_W-1:0] ref_a;
      begin
         hit = (a == ref_a);
      end
   endfunction

   ////////////////////////////////////////////////////////////
   // asynchronous inputs

   // first stage feeds only the second stage
   always @(posedge clock) begin
      if (rst) begin
         osc_meta_reg <= 1'b0;
         osc_sync_reg <= 1'b0;
         osc_prev_reg <= 1'b0;
         fld_meta_reg <= 1'b0;
         fld_sync_reg <= 1'b0;
         fld_prev_reg <= 1'b0;
         wl_prev_reg  <= 1'b0;
      end else begin
         osc_meta_reg <= osc_stable_pin;
         osc_sync_reg <= osc_meta_reg;
         osc_prev_reg <= osc_sync_reg;
         fld_meta_reg <= ext_field_pin;
         fld_sync_reg <= fld_meta_reg;
         fld_prev_reg <= fld_sync_reg;
         wl_prev_reg  <= wl_level;
      end
   end

   assign osc_rise = osc_sync_reg & ~osc_prev_reg;
   assign fld_rise = fld_sync_reg & ~fld_prev_reg;
   assign fld_fall = ~fld_sync_reg & fld_prev_reg;

   ////////////////////////////////////////////////////////////
   // mask registers

   always @(posedge clock) begin
      if (rst || set_default_cmd) begin
         main_mask_reg <= `NRIM_RESET_VAL;
         tnfc_mask_reg <= `NRIM_RESET_VAL;
         err_mask_reg  <= `NRIM_RESET_VAL;
      end else if (wr_en) begin
         if (hit(addr, `NRIM_MAIN_MASK)) begin
            main_mask_reg <= wdata;
         end
         if (hit(addr, `NRIM_TNFC_MASK)) begin
            tnfc_mask_reg <= wdata;
         end
         if (hit(addr, `NRIM_ERR_MASK)) begin
            err_mask_reg <= wdata;
         end
      end
   end

   assign mask_soft_framing = err_mask_reg[`NRIM_E_SOFT];
   assign mask_hard_framing = err_mask_reg[`NRIM_E_HARD];
   assign mask_wakeup_timer = err_mask_reg[`NRIM_E_WT];

   ////////////////////////////////////////////////////////////
   // read-to-clear strobes

   assign rd_main = rd_en && hit(addr, `NRIM_MAIN_STAT);
   assign rd_tnfc = rd_en && hit(addr, `NRIM_TNFC_STAT);
   assign rd_err  = rd_en && hit(addr, `NRIM_ERR_STAT);

   ////////////////////////////////////////////////////////////
   // fifo water level

   // edge of the combined level, so a level held high gives one event
   assign wl_level = (rx_active & fifo_near_full)
                   | (tx_active & fifo_near_empty);

   assign fifo_level_flag = wl_level & ~wl_prev_reg;

   ////////////////////////////////////////////////////////////
   // collision avoidance sequence

   // the field level is sampled once, in the sense state
   assign ca_collide = (ca_state_reg == CA_SENSE) & fld_sync_reg;
   assign ca_clear   = (ca_state_reg == CA_SENSE) & ~fld_sync_reg;

   always @* begin
      ca_state_next = ca_state_reg;
      case (ca_state_reg)
         CA_IDLE: begin
            if (ca_start) begin
               ca_state_next = CA_SENSE;
            end
         end
         CA_SENSE: begin
            if (fld_sync_reg) begin
               ca_state_next = CA_IDLE;
            end else begin
               ca_state_next = CA_GUARD;
            end
         end
         CA_GUARD: begin
            if (guard_done) begin
               ca_state_next = CA_IDLE;
            end
         end
         default: begin
            ca_state_next = CA_IDLE;
         end
      endcase
   end

   always @(posedge clock) begin
      if (rst || set_default_cmd) begin
         ca_state_reg <= CA_IDLE;
         field_on_reg <= 1'b0;
      end else begin
         ca_state_reg <= ca_state_next;
         if (ca_clear) begin
            field_on_reg <= 1'b1;
         end
      end
   end

   // guard time runs from field switch-on
   nrim_guard_timer #(
      .CYCLES (GUARD_CYCLES)
   ) u_guard (
      .clock (clock),
      .rst   (rst),
      .abort (set_default_cmd),
      .start (ca_clear),
      .busy  (),
      .done  (guard_done)
   );

   ////////////////////////////////////////////////////////////
   // status set and clear vectors

   always @* begin
      tnfc_set = 8'h00;
      tnfc_set[`NRIM_T_DCT]  = dir_cmd_done;
      tnfc_set[`NRIM_T_NRE]  = nrt_expire;
      tnfc_set[`NRIM_T_GPE]  = gpt_expire;
      tnfc_set[`NRIM_T_EON]  = fld_rise;
      tnfc_set[`NRIM_T_EOF]  = fld_fall;
      tnfc_set[`NRIM_T_CAC]  = ca_collide;
      tnfc_set[`NRIM_T_CAT]  = guard_done;
      tnfc_set[`NRIM_T_NFCT] = target_mode & bitrate_found;
   end

   assign tnfc_clr = rd_tnfc ? 8'hff : 8'h00;

   assign err_set = err_events;
   assign err_clr = rd_err ? 8'hff : 8'h00;

   always @* begin
      main_set = 8'h00;
      main_set[`NRIM_M_OSC] = osc_rise & osc_enable;
      main_set[`NRIM_M_WL]  = fifo_level_flag;
      main_set[`NRIM_M_RXS] = rx_start;
      main_set[`NRIM_M_RXE] = rx_end;
      main_set[`NRIM_M_TXE] = tx_end;
      main_set[`NRIM_M_COL] = bit_collision;
      main_set[`NRIM_M_TIM] = |tnfc_set;
      main_set[`NRIM_M_ERR] = |err_set;
   end

   always @* begin
      main_clr = rd_main ? `NRIM_MAIN_RDCLR : 8'h00;
      main_clr[`NRIM_M_TIM] = rd_tnfc;
      main_clr[`NRIM_M_ERR] = rd_err;
   end

   ////////////////////////////////////////////////////////////
   // status registers

   // one bank for all three registers, vectors kept bit-aligned
   nrim_flag_bank #(
      .W (24)
   ) u_flags (
      .clock   (clock),
      .rst     (rst),
      .clr_all (set_default_cmd),
      .set_vec ({main_set, tnfc_set, err_set}),
      .clr_vec ({main_clr, tnfc_clr, err_clr}),
      .flags   ({main_flags, tnfc_flags, err_flags})
   );

   ////////////////////////////////////////////////////////////
   // interrupt request

   // summary bits have no mask and are left out: their details count
   assign main_pend = main_flags & ~main_mask_reg & `NRIM_MAIN_RDCLR;
   assign tnfc_pend = tnfc_flags & ~tnfc_mask_reg;
   assign err_pend  = {err_flags[7:6] & ~err_mask_reg[7:6],
                       err_flags[`NRIM_E_SOFT] & ~mask_soft_framing,
                       err_flags[`NRIM_E_HARD] & ~mask_hard_framing,
                       err_flags[`NRIM_E_WT] & ~mask_wakeup_timer,
                       err_flags[2:0] & ~err_mask_reg[2:0]};

   always @(posedge clock) begin
      if (rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |{main_pend, tnfc_pend, err_pend};
      end
   end

   ////////////////////////////////////////////////////////////
   // read data

   // shows the value before the read clears it
   always @* begin
      rdata_next = 8'h00;
      if (rd_en) begin
         case (addr)
            `NRIM_MAIN_MASK: rdata_next = main_mask_reg;
            `NRIM_TNFC_MASK: rdata_next = tnfc_mask_reg;
            `NRIM_ERR_MASK:  rdata_next = err_mask_reg;
            `NRIM_MAIN_STAT: rdata_next = main_flags;
            `NRIM_TNFC_STAT: rdata_next = tnfc_flags;
            `NRIM_ERR_STAT:  rdata_next = err_flags;
            default:         rdata_next = 8'h00;
         endcase
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata    = rdata_reg;
   assign irq      = irq_reg;
   assign field_on = field_on_reg;

endmodule // nrim_top

`default_nettype wire

// [bench/nrim_top_assertions.sv]
/*
 * checker for the interrupt status block: read port, irq and field output.
 * assumes: bound to nrim_top, one clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "nrim_regs.vh"

module nrim_checker (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic [5:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] rdata,
   input wire logic       set_default_cmd,
   input wire logic       rx_start,
   input wire logic       rx_end,
   input wire logic       tx_end,
   input wire logic       bit_collision,
   input wire logic       dir_cmd_done,
   input wire logic       ca_start,
   input wire logic [7:0] err_events,
   input wire logic       irq,
   input wire logic       field_on
);
   logic [7:0] mask_reg [0:2];
   wire        main_ev = rx_start | rx_end | tx_end | bit_collision;

   // shadow masks, so an irq claim can be tied to the mask in force
   always @(posedge clock) begin
      for (int i = 0; i < 3; i++) begin
         if (rst || set_default_cmd)
            mask_reg[i] <= 8'h00;
         else if (wr_en && addr == 6'h14 + 6'(i))
            mask_reg[i] <= wdata;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////
   sequence s_rd_main;
      rd_en && addr == `NRIM_MAIN_STAT;
   endsequence
   sequence s_quiet_rd_main;
      rd_en && addr == `NRIM_MAIN_STAT && !$past(main_ev);
   endsequence

   property p_rdata_idle;
      !$past(rd_en) |-> rdata == 8'h00;
   endproperty
   property p_main_clear;
      s_rd_main ##1 s_quiet_rd_main |=> rdata[5:2] == 4'h0;
   endproperty
   property p_dflt_irq;
      set_default_cmd |-> ##2 !irq;
   endproperty
   property p_dflt_field;
      set_default_cmd |=> !field_on;
   endproperty
   property p_col_irq;
      bit_collision && !set_default_cmd ##1 !mask_reg[0][2] |=> irq;
   endproperty
   property p_dct_irq;
      dir_cmd_done && !set_default_cmd ##1 !mask_reg[1][7] |=> irq;
   endproperty
   property p_crc_irq;
      err_events[7] && !set_default_cmd ##1 !mask_reg[2][7] |=> irq;
   endproperty
   property p_field_rise;
      $rose(field_on) |-> $past(ca_start, 2);
   endproperty

   a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero when idle");
   a_main_clear: assert property (p_main_clear) else $error("main read did not clear");
   a_dflt_irq: assert property (p_dflt_irq) else $error("irq after set default");
   a_dflt_field: assert property (p_dflt_field) else $error("field after set default");
   a_col_irq: assert property (p_col_irq) else $error("collision irq missing");
   a_dct_irq: assert property (p_dct_irq) else $error("command irq missing");
   a_crc_irq: assert property (p_crc_irq) else $error("crc irq missing");
   a_field_rise: assert property (p_field_rise) else $error("field on without start");
endmodule // nrim_checker

bind nrim_top nrim_checker u_nrim_checker (
   .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
   .rd_en(rd_en), .rdata(rdata), .set_default_cmd(set_default_cmd),
   .rx_start(rx_start), .rx_end(rx_end), .tx_end(tx_end),
   .bit_collision(bit_collision), .dir_cmd_done(dir_cmd_done),
   .ca_start(ca_start), .err_events(err_events), .irq(irq), .field_on(field_on)
);
`default_nettype wire

// [bench/nrim_host_model.sv]
/*
 * host model driving the register port of the interrupt block.
 * assumes: one access per call, strobes change right after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module nrim_host_model (
   input  wire logic       clock,
   output var  logic [5:0] addr,
   output var  logic [7:0] wdata,
   output var  logic       wr_en,
   output var  logic       rd_en
);
   initial begin
      addr = 6'h00;
      wdata = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
   end

   // strobes stay set until the next call or idle(); calls may follow each other with no gap
   task access(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_en <= w;
      rd_en <= !w;
   endtask

   // a released bus shows a changed pattern, never the last value
   task idle();
      @(posedge clock);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      addr <= ~addr;
      wdata <= ~wdata;
   endtask
endmodule // nrim_host_model
`default_nettype wire

// [bench/nfc_reader_irq_status_mask_test.sv]
/*
 * self-checking bench of the interrupt status and mask block.
 * assumes: nrim_top with a short guard count, host model on the port.
 */
`timescale 1ns/1ps
`default_nettype none
`include "nrim_regs.vh"

module nfc_reader_irq_status_mask_test;
   localparam int GUARD = 8;
   logic       clock, rst, wr_en, rd_en, irq, field_on, rd_d;
   logic [5:0] addr;
   logic [7:0] wdata, rdata, err_events, m;
   logic       set_default_cmd, osc_enable, osc_stable_pin, rx_active;
   logic       tx_active, fifo_near_full, fifo_near_empty;
   logic       ext_field_pin, ca_start, target_mode, bitrate_found;
   logic [3:0] main_ev;
   logic [2:0] tim_ev;
   logic [7:0] exp_q [$];
   logic [31:0] seed;
   int         errors, total_checks, cycles;

   nrim_host_model u_nrim_host_model (.clock(clock), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en));
   nrim_top #(.GUARD_CYCLES(GUARD)) u_nrim_top (.clock(clock), .rst(rst), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .set_default_cmd(set_default_cmd), .osc_enable(osc_enable),
      .osc_stable_pin(osc_stable_pin), .rx_active(rx_active), .tx_active(tx_active),
      .fifo_near_full(fifo_near_full), .fifo_near_empty(fifo_near_empty),
      .rx_start(main_ev[3]), .rx_end(main_ev[2]), .tx_end(main_ev[1]),
      .bit_collision(main_ev[0]), .dir_cmd_done(tim_ev[2]), .nrt_expire(tim_ev[1]),
      .gpt_expire(tim_ev[0]), .ext_field_pin(ext_field_pin), .ca_start(ca_start),
      .target_mode(target_mode), .bitrate_found(bitrate_found),
      .err_events(err_events), .irq(irq), .field_on(field_on));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task check_rd(input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task check_irq(input logic e);
      #1;
      check_rd({7'h00, e}, {7'h00, irq});
   endtask

   task check_fld(input logic e);
      #1;
      check_rd({7'h00, e}, {7'h00, field_on});
   endtask

   task tally_and_finish();
      errors += exp_q.size();
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task rd(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_nrim_host_model.access(1'b0, a, 8'h00);
   endtask

   task wr(input logic [5:0] a, input logic [7:0] d);
      u_nrim_host_model.access(1'b1, a, d);
   endtask

   task pulse(input logic [3:0] mv, input logic [2:0] t, input logic [7:0] e,
              input logic c, input logic b);
      @(posedge clock);
      main_ev <= mv;
      tim_ev <= t;
      err_events <= e;
      ca_start <= c;
      bitrate_found <= b;
      @(posedge clock);
      main_ev <= 4'h0;
      tim_ev <= 3'h0;
      err_events <= 8'h00;
      ca_start <= 1'b0;
      bitrate_found <= 1'b0;
      repeat (4) @(posedge clock);
   endtask

   // six mapped registers, then one unmapped place
   task zero_regs();
      for (int i = 0; i < 7; i++)
         rd(6'h14 + 6'(i), 8'h00);
      u_nrim_host_model.idle();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // read data stand only in the cycle after the strobe
   always @(posedge clock) begin
      rd_d <= rd_en && !rst;
      cycles <= cycles + 1;
      if (rd_d)
         check_rd(exp_q.pop_front(), rdata);
      if (cycles == 3000) begin
         errors++;
         tally_and_finish();
      end
   end

   initial begin
      {rst, set_default_cmd, osc_enable, osc_stable_pin, rx_active} = 5'h10;
      {tx_active, fifo_near_full, fifo_near_empty, ext_field_pin} = 4'h0;
      {ca_start, target_mode, bitrate_found, main_ev, tim_ev} = 10'h000;
      err_events = 8'h00;
      seed = 32'hc9c1_ed71;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      zero_regs();
      for (int k = 0; k < 4; k++) begin
         pulse(4'h8 >> k, 3'h0, 8'h00, 1'b0, 1'b0);
         check_irq(1'b1);
         rd(`NRIM_MAIN_STAT, 8'h20 >> k);
         rd(`NRIM_MAIN_STAT, 8'h00);
         u_nrim_host_model.idle();
         repeat (2) @(posedge clock);
         check_irq(1'b0);
      end
      wr(`NRIM_MAIN_MASK, 8'h3c);
      u_nrim_host_model.idle();
      pulse(4'hf, 3'h0, 8'h00, 1'b0, 1'b0);
      check_irq(1'b0);
      rd(`NRIM_MAIN_STAT, 8'h3c);
      {osc_enable, osc_stable_pin, rx_active, fifo_near_full} <= 4'hf;
      u_nrim_host_model.idle();
      repeat (5) @(posedge clock);
      rd(`NRIM_MAIN_STAT, 8'hc0);
      rx_active <= 1'b0;
      u_nrim_host_model.idle();
      {tx_active, fifo_near_empty} <= 2'h3;
      repeat (3) @(posedge clock);
      rd(`NRIM_MAIN_STAT, 8'h40);
      tx_active <= 1'b0;
      ext_field_pin <= 1'b1;
      u_nrim_host_model.idle();
      pulse(4'h0, 3'h7, 8'h00, 1'b0, 1'b0);
      rd(`NRIM_MAIN_STAT, 8'h02);
      rd(`NRIM_MAIN_STAT, 8'h02);
      rd(`NRIM_TNFC_STAT, 8'hf0);
      rd(`NRIM_MAIN_STAT, 8'h00);
      u_nrim_host_model.idle();
      pulse(4'h0, 3'h0, 8'h00, 1'b1, 1'b0);
      check_fld(1'b0);
      rd(`NRIM_TNFC_STAT, 8'h04);
      ext_field_pin <= 1'b0;
      u_nrim_host_model.idle();
      pulse(4'h0, 3'h0, 8'h00, 1'b0, 1'b1);
      target_mode <= 1'b1;
      pulse(4'h0, 3'h0, 8'h00, 1'b0, 1'b1);
      rd(`NRIM_TNFC_STAT, 8'h09);
      u_nrim_host_model.idle();
      pulse(4'h0, 3'h0, 8'h00, 1'b1, 1'b0);
      check_fld(1'b1);
      rd(`NRIM_TNFC_STAT, 8'h00);
      u_nrim_host_model.idle();
      repeat (GUARD) @(posedge clock);
      rd(`NRIM_TNFC_STAT, 8'h02);
      for (int k = 0; k < 2; k++) begin
         seed = lfsr(seed);
         m = k ? 8'hff : seed[7:0] & 8'h7f;
         wr(`NRIM_ERR_MASK, m);
         rd(`NRIM_ERR_MASK, m);
         u_nrim_host_model.idle();
         pulse(4'h0, 3'h0, 8'hff, 1'b0, 1'b0);
         check_irq(k == 0);
         rd(`NRIM_MAIN_STAT, 8'h01);
         rd(`NRIM_ERR_STAT, 8'hff);
         rd(`NRIM_MAIN_STAT, 8'h00);
      end
      wr(`NRIM_MAIN_MASK, 8'hff);
      wr(`NRIM_TNFC_MASK, 8'hff);
      u_nrim_host_model.idle();
      pulse(4'hf, 3'h7, 8'hff, 1'b0, 1'b0);
      set_default_cmd <= 1'b1;
      @(posedge clock);
      set_default_cmd <= 1'b0;
      zero_regs();
      check_irq(1'b0);
      check_fld(1'b0);
      repeat (2) @(posedge clock);
      tally_and_finish();
   end
endmodule // nfc_reader_irq_status_mask_test
`default_nettype wire
